/* verilog/smd_spi_master_unit_core.sv */
`include "smd_map.svh"
`default_nettype none
module smd_spi_master_unit_core
   import smd_pkg::*;
(
   input  wire logic        clk_sys_i,
   input  wire logic        srst_i,
   input  wire logic [11:0] reg_addr_i,
   input  wire logic [31:0] reg_wdata_i,
   input  wire logic        reg_wr_i,
   input  wire logic        reg_rd_i,
   output logic      [31:0] reg_rdata_o,
   output logic             mem_rd_o,
   output logic      [31:0] mem_raddr_o,
   input  wire logic [7:0]  mem_rdata_i,
   output logic             mem_wr_o,
   output logic      [31:0] mem_waddr_o,
   output logic      [7:0]  mem_wdata_o,
   output logic             sck_o,
   output logic             mosi_o,
   input  wire logic        miso_i,
   output logic             csn_o,
   output logic             busy_o,
   output logic             end_o
);
   // ****************************************
   // Registers and state
   // ****************************************
   logic [31:0] rate_ff, rx_ptr_ff, tx_ptr_ff;
   logic [15:0] rx_max_ff, tx_max_ff, rx_amt_ff, tx_amt_ff;
   logic        rx_list_ff, tx_list_ff, selpol_ff;
   smd_fmt_t    fmt_ff;
   logic [7:0]  rxdly_ff, guard_ff, orc_ff;
   logic [31:0] dcpsel_ff, dccfg_ff;
   smd_state_t  state_ff;
   logic [9:0]  cnt_ff, half_cnt_ff, smp_cnt_ff;
   logic [4:0]  edge_ff;
   logic [15:0] rx_lim_ff, tx_lim_ff, total_ff, byte_ff, rx_idx_ff, tx_idx_ff;
   logic [7:0]  tx_sh_ff, rx_sh_ff, cur_tx_ff;
   logic [3:0]  rx_bits_ff;
   logic        smp_pend_ff, fetch_ok_ff;
   logic        m1_ff, m2_ff, m3_ff, miso_ff;
   logic [9:0]  half_cyc, dly_cyc, guard_cyc;
   logic        start_req, edge_now, lead_edge, smp_edge, shf_edge, capture;

   // ****************************************
   // Rate and timing conversions
   // ****************************************
   // Half periods in 5 ns cycles; 8M and up round down to the 5 ns grid.
   // rate code lookup
   always_comb begin
      unique case (rate_ff)
         `SMD_R125K: half_cyc = 10'd800;
         `SMD_R500K: half_cyc = 10'd200;
         `SMD_R1M:   half_cyc = 10'd100;
         `SMD_R2M:   half_cyc = 10'd50;
         `SMD_R4M:   half_cyc = 10'd25;
         `SMD_R8M:   half_cyc = 10'd12;
         `SMD_R16M:  half_cyc = 10'd6;
         `SMD_R32M:  half_cyc = 10'd3;
         default:    half_cyc = 10'd400; // Undefined codes run at 250 kbps.
      endcase
   end

   // One 64 MHz cycle is 3.125 system cycles; minimum times round up.
   // delay in 64 MHz units
   assign dly_cyc   = 10'((13'(rxdly_ff) * 13'd25 + 13'd7) >> 3);
   assign guard_cyc = 10'((13'(guard_ff) * 13'd25 + 13'd7) >> 3);

   assign start_req = reg_wr_i && (reg_addr_i == `SMD_OFS_START) && reg_wdata_i[0];
   assign edge_now  = (state_ff == ST_SHIFT) && (edge_ff < 5'd16)
                      && (half_cnt_ff == half_cyc - 10'd1);
   assign lead_edge = ~edge_ff[0];
   assign smp_edge  = edge_now && (fmt_ff.cpha ? ~lead_edge : lead_edge);
   assign shf_edge  = edge_now && (fmt_ff.cpha ? lead_edge : (~lead_edge && edge_ff != 5'd15));
   assign capture   = smp_pend_ff && (smp_cnt_ff == 10'd0);

   // ****************************************
   // Register bus
   // ****************************************
   // Writes land in the cycle after the strobe; the engine reads them live, except the maxima, which a start latches.
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         rate_ff    <= `SMD_RST_RATE;
         rx_max_ff  <= 16'h0000;
         tx_max_ff  <= 16'h0000;
         rx_list_ff <= 1'b0;
         tx_list_ff <= 1'b0;
         fmt_ff     <= '0;
         rxdly_ff   <= `SMD_RST_RXDLY;
         guard_ff   <= `SMD_RST_GUARD;
         selpol_ff  <= 1'b0;
         orc_ff     <= 8'h00;
         dcpsel_ff  <= 32'hffff_ffff;
         dccfg_ff   <= 32'h0000_0000;
      end else if (reg_wr_i) begin
         unique case (reg_addr_i)
            `SMD_OFS_RATE:    rate_ff    <= reg_wdata_i;
            `SMD_OFS_RX_MAX:  rx_max_ff  <= reg_wdata_i[15:0];
            `SMD_OFS_TX_MAX:  tx_max_ff  <= reg_wdata_i[15:0];
            `SMD_OFS_RX_LIST: rx_list_ff <= reg_wdata_i[0];
            `SMD_OFS_TX_LIST: tx_list_ff <= reg_wdata_i[0];
            `SMD_OFS_FORMAT:  fmt_ff     <= reg_wdata_i[2:0];
            `SMD_OFS_RXDLY:   rxdly_ff   <= reg_wdata_i[7:0];
            `SMD_OFS_GUARD:   guard_ff   <= reg_wdata_i[7:0];
            `SMD_OFS_SELPOL:  selpol_ff  <= reg_wdata_i[0];
            `SMD_OFS_DCPSEL:  dcpsel_ff  <= reg_wdata_i;
            `SMD_OFS_DCCFG:   dccfg_ff   <= reg_wdata_i;
            `SMD_OFS_ORC:     orc_ff     <= reg_wdata_i[7:0];
            default: ;
         endcase
      end
   end

   // Pointers advance by one buffer at the end when array list mode is on.
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         rx_ptr_ff <= 32'h0000_0000;
         tx_ptr_ff <= 32'h0000_0000;
      end else if (reg_wr_i && reg_addr_i == `SMD_OFS_RX_PTR) begin
         rx_ptr_ff <= reg_wdata_i;
      end else if (reg_wr_i && reg_addr_i == `SMD_OFS_TX_PTR) begin
         tx_ptr_ff <= reg_wdata_i;
      end else if (end_o) begin
         if (rx_list_ff) rx_ptr_ff <= rx_ptr_ff + 32'(rx_lim_ff);
         if (tx_list_ff) tx_ptr_ff <= tx_ptr_ff + 32'(tx_lim_ff);
      end
   end

   // Read data stands only in the cycle after the strobe; unmapped reads 0.
   always_ff @(posedge clk_sys_i) begin
      if (srst_i || !reg_rd_i) begin
         reg_rdata_o <= 32'h0000_0000;
      end else begin
         unique case (reg_addr_i)
            `SMD_OFS_STATUS:  reg_rdata_o <= {29'h0, state_ff};
            `SMD_OFS_RATE:    reg_rdata_o <= rate_ff;
            `SMD_OFS_RX_PTR:  reg_rdata_o <= rx_ptr_ff;
            `SMD_OFS_RX_MAX:  reg_rdata_o <= {16'h0, rx_max_ff};
            `SMD_OFS_RX_AMT:  reg_rdata_o <= {16'h0, rx_amt_ff};
            `SMD_OFS_RX_LIST: reg_rdata_o <= {31'h0, rx_list_ff};
            `SMD_OFS_TX_PTR:  reg_rdata_o <= tx_ptr_ff;
            `SMD_OFS_TX_MAX:  reg_rdata_o <= {16'h0, tx_max_ff};
            `SMD_OFS_TX_AMT:  reg_rdata_o <= {16'h0, tx_amt_ff};
            `SMD_OFS_TX_LIST: reg_rdata_o <= {31'h0, tx_list_ff};
            `SMD_OFS_FORMAT:  reg_rdata_o <= {29'h0, fmt_ff};
            `SMD_OFS_RXDLY:   reg_rdata_o <= {24'h0, rxdly_ff};
            `SMD_OFS_GUARD:   reg_rdata_o <= {24'h0, guard_ff};
            `SMD_OFS_SELPOL:  reg_rdata_o <= {31'h0, selpol_ff};
            `SMD_OFS_DCPSEL:  reg_rdata_o <= dcpsel_ff;
            `SMD_OFS_DCCFG:   reg_rdata_o <= dccfg_ff;
            `SMD_OFS_ORC:     reg_rdata_o <= {24'h0, orc_ff};
            default:          reg_rdata_o <= 32'h0000_0000;
         endcase
      end
   end

   // ****************************************
   // Transaction sequencer
   // ****************************************
   // A start while busy is ignored; maxima are frozen for the transaction.
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         state_ff  <= ST_IDLE;
         cnt_ff    <= 10'd0;
         rx_lim_ff <= 16'h0000;
         tx_lim_ff <= 16'h0000;
         total_ff  <= 16'h0000;
         byte_ff   <= 16'h0000;
      end else begin
         cnt_ff <= cnt_ff + 10'd1;
         unique case (state_ff)
            ST_IDLE: begin
               if (start_req) begin
                  state_ff  <= ST_START;
                  cnt_ff    <= 10'd0;
                  rx_lim_ff <= rx_max_ff;
                  tx_lim_ff <= tx_max_ff;
                  total_ff  <= (rx_max_ff > tx_max_ff) ? rx_max_ff : tx_max_ff;
                  byte_ff   <= 16'h0000;
               end
            end
            ST_START: if (cnt_ff >= `SMD_START_CYC - 10'd1) begin
               state_ff <= ST_LEAD;
               cnt_ff   <= 10'd0;
            end
            ST_LEAD: if (cnt_ff >= guard_cyc) begin
               state_ff <= (total_ff == 16'h0000) ? ST_TRAIL : ST_FETCH;
               cnt_ff   <= 10'd0;
            end
            ST_FETCH: state_ff <= ST_LOAD;
            ST_LOAD:  state_ff <= ST_SHIFT;
            ST_SHIFT: if (edge_ff == 5'd16 && !smp_pend_ff && half_cnt_ff >= half_cyc) begin
               byte_ff  <= byte_ff + 16'h0001;
               state_ff <= (byte_ff + 16'h0001 < total_ff) ? ST_FETCH : ST_TRAIL;
               cnt_ff   <= 10'd0;
            end
            ST_TRAIL: if (cnt_ff >= guard_cyc) begin
               state_ff <= ST_GAP;
               cnt_ff   <= 10'd0;
            end
            ST_GAP: if (cnt_ff >= guard_cyc) state_ff <= ST_IDLE;
         endcase
      end
   end

   assign busy_o = (state_ff != ST_IDLE);

   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         end_o     <= 1'b0;
         rx_amt_ff <= 16'h0000;
         tx_amt_ff <= 16'h0000;
      end else begin
         end_o <= (state_ff == ST_GAP) && (cnt_ff >= guard_cyc);
         if (state_ff == ST_TRAIL && cnt_ff >= guard_cyc) begin
            rx_amt_ff <= rx_idx_ff;
            tx_amt_ff <= tx_idx_ff;
         end
      end
   end

   // ****************************************
   // Transmit path
   // ****************************************
   // Memory answers in the cycle its read strobe stands, which is LOAD, so the byte is taken in LOAD.
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         mem_rd_o    <= 1'b0;
         mem_raddr_o <= 32'h0000_0000;
         fetch_ok_ff <= 1'b0;
         tx_idx_ff   <= 16'h0000;
         cur_tx_ff   <= 8'h00;
      end else begin
         mem_rd_o <= 1'b0;
         if (state_ff == ST_IDLE && start_req) tx_idx_ff <= 16'h0000;
         if (state_ff == ST_FETCH) begin
            fetch_ok_ff <= (tx_idx_ff < tx_lim_ff);
            if (tx_idx_ff < tx_lim_ff) begin
               mem_rd_o    <= 1'b1;
               mem_raddr_o <= tx_ptr_ff + 32'(tx_idx_ff);
               tx_idx_ff   <= tx_idx_ff + 16'h0001;
            end
         end
         if (state_ff == ST_LOAD) cur_tx_ff <= fetch_ok_ff ? mem_rdata_i : orc_ff;
      end
   end

   // Bit clock and shift register; SCK rests at the polarity level.
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         half_cnt_ff <= 10'd0;
         edge_ff     <= 5'd0;
         tx_sh_ff    <= 8'h00;
         mosi_o      <= 1'b0;
         sck_o       <= 1'b0;
      end else if (state_ff == ST_LOAD) begin
         half_cnt_ff <= 10'd0;
         edge_ff     <= 5'd0;
         sck_o       <= fmt_ff.cpol;
         tx_sh_ff    <= fetch_ok_ff ? mem_rdata_i : orc_ff;
         // Phase 0 must present the first bit before the leading edge.
         if (!fmt_ff.cpha) begin
            mosi_o   <= fmt_ff.lsb ? (fetch_ok_ff ? mem_rdata_i[0] : orc_ff[0])
                                   : (fetch_ok_ff ? mem_rdata_i[7] : orc_ff[7]);
            tx_sh_ff <= fmt_ff.lsb ? ((fetch_ok_ff ? mem_rdata_i : orc_ff) >> 1)
                                   : ((fetch_ok_ff ? mem_rdata_i : orc_ff) << 1);
         end
      end else if (state_ff == ST_SHIFT) begin
         half_cnt_ff <= edge_now ? 10'd0 : half_cnt_ff + ((half_cnt_ff < half_cyc) ? 10'd1 : 10'd0);
         if (edge_now) begin
            edge_ff <= edge_ff + 5'd1;
            sck_o   <= ~sck_o;
         end
         if (shf_edge) begin
            mosi_o   <= fmt_ff.lsb ? tx_sh_ff[0] : tx_sh_ff[7];
            tx_sh_ff <= fmt_ff.lsb ? (tx_sh_ff >> 1) : (tx_sh_ff << 1);
         end
      end else begin
         sck_o <= fmt_ff.cpol;
      end
   end

   // ****************************************
   // Receive path
   // ****************************************
   // Three stages; a level counts only once the last two agree.
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         m1_ff   <= 1'b0;
         m2_ff   <= 1'b0;
         m3_ff   <= 1'b0;
         miso_ff <= 1'b0;
      end else begin
         m1_ff <= miso_i;
         m2_ff <= m1_ff;
         m3_ff <= m2_ff;
         if (m2_ff == m3_ff) miso_ff <= m3_ff;
      end
   end

   // The synchroniser adds latency; the delay register holds the sample back to cover it.
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         smp_pend_ff <= 1'b0;
         smp_cnt_ff  <= 10'd0;
         rx_sh_ff    <= 8'h00;
         rx_bits_ff  <= 4'd0;
         rx_idx_ff   <= 16'h0000;
         mem_wr_o    <= 1'b0;
         mem_waddr_o <= 32'h0000_0000;
         mem_wdata_o <= 8'h00;
      end else begin
         mem_wr_o <= 1'b0;
         if (state_ff == ST_IDLE && start_req) begin
            rx_idx_ff  <= 16'h0000;
            rx_bits_ff <= 4'd0;
         end
         if (smp_edge) begin
            smp_pend_ff <= 1'b1;
            smp_cnt_ff  <= dly_cyc;
         end else if (smp_pend_ff && !capture) begin
            smp_cnt_ff <= smp_cnt_ff - 10'd1;
         end else if (capture) begin
            smp_pend_ff <= 1'b0;
         end
         if (capture) begin
            rx_sh_ff   <= fmt_ff.lsb ? {miso_ff, rx_sh_ff[7:1]} : {rx_sh_ff[6:0], miso_ff};
            rx_bits_ff <= (rx_bits_ff == 4'd7) ? 4'd0 : rx_bits_ff + 4'd1;
            if (rx_bits_ff == 4'd7 && rx_idx_ff < rx_lim_ff) begin
               mem_wr_o    <= 1'b1;
               mem_waddr_o <= rx_ptr_ff + 32'(rx_idx_ff);
               mem_wdata_o <= fmt_ff.lsb ? {miso_ff, rx_sh_ff[7:1]} : {rx_sh_ff[6:0], miso_ff};
               rx_idx_ff   <= rx_idx_ff + 16'h0001;
            end
         end
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (srst_i) csn_o <= 1'b1;
      else if (state_ff inside {ST_IDLE, ST_START, ST_GAP}) csn_o <= ~selpol_ff;
      else csn_o <= selpol_ff;
   end

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (srst_i);

   a_rate_half: assert property (
      (state_ff == ST_SHIFT && rate_ff == `SMD_R32M && edge_now) |=> !edge_now [*2])
      else $error("clock edges closer than the 32M half period");
   a_rx_store_cap: assert property (
      mem_wr_o |-> (rx_idx_ff <= rx_lim_ff) && (rx_idx_ff != 16'h0000))
      else $error("receive store beyond maximum");
   a_tx_read_cap: assert property (
      mem_rd_o |-> (tx_idx_ff <= tx_lim_ff) && $past(state_ff) == ST_FETCH)
      else $error("transmit read beyond maximum");
   a_amount_end: assert property (
      end_o |-> rx_amt_ff == rx_idx_ff && tx_amt_ff == tx_idx_ff)
      else $error("amount registers not updated at end");
   a_sck_idle: assert property (
      (state_ff == ST_LEAD) |-> sck_o == fmt_ff.cpol)
      else $error("clock not at idle level before bits");
   a_sample_wait: assert property (
      (smp_edge && dly_cyc == 10'd4) |=> !capture [*4] ##1 capture)
      else $error("sample delay not honoured");
   a_select_idle: assert property (
      (state_ff == ST_IDLE && $past(state_ff) == ST_IDLE) |-> csn_o == ~$past(selpol_ff))
      else $error("select not at idle level");
   a_orc_sent: assert property (
      (state_ff == ST_LOAD && !fetch_ok_ff) |=> cur_tx_ff == $past(orc_ff))
      else $error("over-read byte not used");
   a_start_delay: assert property (
      (state_ff == ST_IDLE && start_req) |=> (state_ff == ST_START) [*8])
      else $error("transmission started too early");
   a_total_len: assert property (
      (state_ff == ST_SHIFT ##1 state_ff == ST_TRAIL) |-> byte_ff == total_ff)
      else $error("byte count differs from larger maximum");

   c_end: cover property (end_o);
   c_overread: cover property (state_ff == ST_LOAD && !fetch_ok_ff);
   c_lsb_end: cover property (end_o && fmt_ff.lsb && fmt_ff.cpha);
endmodule
`default_nettype wire

/* inc/smd_map.svh */
`ifndef SMD_MAP_SVH
`define SMD_MAP_SVH
`define SMD_OFS_START    12'h010
`define SMD_OFS_STATUS   12'h400
`define SMD_OFS_RATE     12'h524
`define SMD_OFS_RX_PTR   12'h534
`define SMD_OFS_RX_MAX   12'h538
`define SMD_OFS_RX_AMT   12'h53c
`define SMD_OFS_RX_LIST  12'h540
`define SMD_OFS_TX_PTR   12'h544
`define SMD_OFS_TX_MAX   12'h548
`define SMD_OFS_TX_AMT   12'h54c
`define SMD_OFS_TX_LIST  12'h550
`define SMD_OFS_FORMAT   12'h554
`define SMD_OFS_RXDLY    12'h560
`define SMD_OFS_GUARD    12'h564
`define SMD_OFS_SELPOL   12'h568
`define SMD_OFS_DCPSEL   12'h56c
`define SMD_OFS_DCCFG    12'h570
`define SMD_OFS_ORC      12'h5c0
`define SMD_RST_RATE     32'h0400_0000
`define SMD_RST_RXDLY    8'h02
`define SMD_RST_GUARD    8'h02
`define SMD_FMT_ORDER    0
`define SMD_FMT_CPHA     1
`define SMD_FMT_CPOL     2
`define SMD_CLK_NS       5
`define SMD_START_NS     1000
`define SMD_START_CYC    10'((`SMD_START_NS + `SMD_CLK_NS - 1) / `SMD_CLK_NS)
`define SMD_R125K        32'h0200_0000
`define SMD_R250K        32'h0400_0000
`define SMD_R500K        32'h0800_0000
`define SMD_R1M          32'h1000_0000
`define SMD_R2M          32'h2000_0000
`define SMD_R4M          32'h4000_0000
`define SMD_R8M          32'h8000_0000
`define SMD_R16M         32'h00a0_0000
`define SMD_R32M         32'h1400_0000
`endif

/* inc/smd_pkg.sv */
package smd_pkg;
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_START = 3'b001,
      ST_LEAD  = 3'b010,
      ST_FETCH = 3'b011,
      ST_LOAD  = 3'b100,
      ST_SHIFT = 3'b101,
      ST_TRAIL = 3'b110,
      ST_GAP   = 3'b111
   } smd_state_t;
   typedef struct packed {
      logic cpol;
      logic cpha;
      logic lsb;
   } smd_fmt_t;
endpackage

/* tb/smd_spi_slave.sv */
`default_nettype none
// ****************************************************************
// Serial slave standing on the far side of the link
// ****************************************************************
module smd_spi_slave (
   input  wire logic sck_i,
   input  wire logic mosi_i,
   input  wire logic csn_i,
   input  wire logic cpol_i,
   input  wire logic cpha_i,
   input  wire logic lsb_i,
   input  wire logic selpol_i,
   output logic      miso_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] tx_b [0:3];
   logic [7:0] rx_b [0:3];
   int         k;

   // Picks the bit that goes out at position n of a byte.
   function automatic logic pick(input logic [7:0] b, input int n);
      return lsb_i ? b[n] : b[7-n];
   endfunction

   // Reply bytes are fixed so the bench can predict what lands in memory.
   initial begin
      miso_o = 1'b0;
      k = 0;
      for (int i = 0; i < 4; i++) begin
         tx_b[i] = 8'(8'hc1 + i * 37);
      end
   end

   // frame start edge
   // A released data line shows the inverse of its last level, never a stale copy.
   always @(csn_i) begin
      if (csn_i === selpol_i) begin
         k = 0;
         if (!cpha_i) begin
            miso_o = pick(tx_b[0], 0);
         end
      end else begin
         miso_o = ~miso_o;
      end
   end

   // sample and shift
   // The sampling edge is the leading one for phase 0 and the trailing one for phase 1.
   always @(sck_i) begin
      if (csn_i === selpol_i) begin
         if ((sck_i ^ cpol_i) ^ cpha_i) begin
            if (lsb_i) begin
               rx_b[(k / 8) % 4][k % 8] = mosi_i;
            end else begin
               rx_b[(k / 8) % 4][7 - k % 8] = mosi_i;
            end
            k++;
         end else begin
            miso_o = pick(tx_b[(k / 8) % 4], k % 8);
         end
      end
   end
endmodule
`default_nettype wire

/* tb/spi_master_dma_config_tb.sv */
`include "smd_map.svh"
`default_nettype none
module spi_master_dma_config_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0] RX_PTR = 32'h0000_1000;
   localparam logic [31:0] TX_PTR = 32'h0000_2000;
   logic        clk_sys_i   = 1'b0;
   logic        srst_i      = 1'b1;
   logic [11:0] reg_addr_i  = 12'h000;
   logic [31:0] reg_wdata_i = 32'h0;
   logic        reg_wr_i    = 1'b0;
   logic        reg_rd_i    = 1'b0;
   logic [7:0]  churn       = 8'h00;
   logic [2:0]  cur_fmt     = 3'h0;
   logic        cur_pol     = 1'b0;
   wire logic [31:0] reg_rdata_o, mem_raddr_o, mem_waddr_o;
   wire logic [7:0]  mem_wdata_o, mem_rdata_i;
   wire logic        mem_rd_o, mem_wr_o, sck_o, mosi_o, miso_w, csn_o, busy_o, end_o;
   logic [7:0]  tx_mem [0:3] = '{8'h3c, 8'h96, 8'h5e, 8'hd2};
   logic [7:0]  wr_data [0:7];
   logic [31:0] wr_addr [0:7];
   logic [31:0] rates [0:8] = '{`SMD_R125K, `SMD_R250K, `SMD_R500K, `SMD_R1M, `SMD_R2M,
                                `SMD_R4M, `SMD_R8M, `SMD_R16M, `SMD_R32M};
   int          halves [0:8] = '{800, 400, 200, 100, 50, 25, 12, 6, 3};
   int          n_rd, n_wr, checks, n_errors;

   smd_spi_master_unit_core smd_spi_master_unit_core_i (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
      .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
      .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .mem_rd_o(mem_rd_o),
      .mem_raddr_o(mem_raddr_o), .mem_rdata_i(mem_rdata_i), .mem_wr_o(mem_wr_o),
      .mem_waddr_o(mem_waddr_o), .mem_wdata_o(mem_wdata_o), .sck_o(sck_o), .mosi_o(mosi_o),
      .miso_i(miso_w), .csn_o(csn_o), .busy_o(busy_o), .end_o(end_o));

   smd_spi_slave smd_spi_slave_i (.sck_i(sck_o), .mosi_i(mosi_o), .csn_i(csn_o),
      .cpol_i(cur_fmt[2]), .cpha_i(cur_fmt[1]), .lsb_i(cur_fmt[0]), .selpol_i(cur_pol),
      .miso_o(miso_w));

   // The clock runs at 200 MHz.
   initial forever #2.5 clk_sys_i = ~clk_sys_i;

   // The core takes the byte in the cycle its read strobe stands, so memory answers then.
   // Outside reads the data bus keeps churning, so a byte taken at the wrong time shows.
   assign mem_rdata_i = mem_rd_o ? tx_mem[2'(mem_raddr_o - TX_PTR)] : churn;
   always @(posedge clk_sys_i) begin
      churn <= ~churn;
      n_rd <= (reg_wr_i && reg_addr_i == `SMD_OFS_START) ? 0 : n_rd + int'(mem_rd_o);
      n_wr <= (reg_wr_i && reg_addr_i == `SMD_OFS_START) ? 0 : n_wr + int'(mem_wr_o);
      if (mem_wr_o) begin
         wr_data[n_wr % 8] <= mem_wdata_o;
         wr_addr[n_wr % 8] <= mem_waddr_o;
      end
   end

   // Prints the counts and the verdict, then ends the run.
   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   // Register bus master: one-cycle strobes launched just after a rising edge.
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_sys_i);
      reg_wr_i <= 1'b1;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      @(posedge clk_sys_i);
      reg_wr_i <= 1'b0;
   endtask

   task automatic rchk(input logic [11:0] a, input logic [31:0] e);
      @(posedge clk_sys_i);
      reg_rd_i <= 1'b1;
      reg_addr_i <= a;
      @(posedge clk_sys_i);
      reg_rd_i <= 1'b0;
      #1 check(reg_rdata_o, e);
   endtask

   // One whole transaction; counting is done on falling edges where outputs are settled.
   task automatic run(input logic [2:0] fmt, input logic pol, input logic [31:0] rate,
                      input int half, input logic [7:0] dly, input int rx, input int tx);
      int n;
      int t;
      n = rx > tx ? rx : tx;
      cur_fmt = fmt;
      cur_pol = pol;
      wr(`SMD_OFS_FORMAT, {29'h0, fmt});
      wr(`SMD_OFS_SELPOL, {31'h0, pol});
      wr(`SMD_OFS_RATE, rate);
      wr(`SMD_OFS_RXDLY, {24'h0, dly});
      wr(`SMD_OFS_RX_MAX, 32'(rx));
      wr(`SMD_OFS_TX_MAX, 32'(tx));
      wr(`SMD_OFS_RX_PTR, RX_PTR);
      wr(`SMD_OFS_TX_PTR, TX_PTR);
      #1 check(32'(sck_o), 32'(fmt[2]));
      check(32'(csn_o), 32'(!pol));
      wr(`SMD_OFS_START, 32'h1);
      #1 check(32'(busy_o), 32'h1);
      t = 0;
      while (csn_o !== pol && t < 400) begin
         @(negedge clk_sys_i);
         t++;
      end
      check(32'(t >= 200 && t <= 210), 32'h1);
      if (n > 0) begin
         t = 0;
         while (sck_o === fmt[2] && t < 2000) begin
            @(negedge clk_sys_i);
            t++;
         end
         check(32'(t >= 7), 32'h1);
         t = 0;
         while (sck_o !== fmt[2] && t < 2000) begin
            @(negedge clk_sys_i);
            t++;
         end
         check(32'(t), 32'(half));
      end
      t = 0;
      while (end_o !== 1'b1 && t < 40000) begin
         @(negedge clk_sys_i);
         t++;
      end
      check(32'(end_o), 32'h1);
      check(32'(busy_o), 32'h0);
      for (int i = 0; i < n; i++)
         check(smd_spi_slave_i.rx_b[i], i < tx ? tx_mem[i] : 8'ha5);
      check(32'(n_rd), 32'(tx));
      check(32'(n_wr), 32'(rx));
      for (int i = 0; i < rx; i++) check(wr_data[i], smd_spi_slave_i.tx_b[i]);
      for (int i = 0; i < rx; i++) check(wr_addr[i], RX_PTR + 32'(i));
      rchk(`SMD_OFS_RX_AMT, 32'(rx));
      rchk(`SMD_OFS_TX_AMT, 32'(tx));
      $display("test done: format %0h, %0d bytes", fmt, n);
   endtask

   // Main sequence: reset values, register access, then transactions in every mode.
   initial begin
      repeat (10) @(posedge clk_sys_i);
      srst_i <= 1'b0;
      rchk(`SMD_OFS_RATE, `SMD_RST_RATE);
      rchk(`SMD_OFS_RXDLY, 32'h2);
      rchk(`SMD_OFS_RX_MAX, 32'h0);
      rchk(`SMD_OFS_TX_MAX, 32'h0);
      rchk(`SMD_OFS_FORMAT, 32'h0);
      rchk(`SMD_OFS_SELPOL, 32'h0);
      wr(`SMD_OFS_TX_AMT, 32'hffff);
      rchk(`SMD_OFS_TX_AMT, 32'h0);
      rchk(12'h7fc, 32'h0);
      wr(`SMD_OFS_ORC, 32'ha5);
      rchk(`SMD_OFS_ORC, 32'ha5);
      $display("test done: registers");
      // A delay of one 64 MHz cycle is four system cycles, the case the sample-wait check watches.
      run(3'b000, 1'b0, `SMD_R4M, 25, 8'h01, 3, 2);
      run(3'b111, 1'b1, `SMD_R2M, 50, 8'h08, 1, 3);
      run(3'b010, 1'b0, `SMD_R1M, 100, 8'h00, 2, 2);
      run(3'b101, 1'b0, `SMD_R8M, 12, 8'h00, 2, 0);
      run(3'b000, 1'b0, `SMD_R4M, 25, 8'h02, 0, 0);
      for (int i = 0; i < 9; i++) run(3'b000, 1'b0, rates[i], halves[i], 8'h00, 0, 1);
      stop_test();
   end

   // Watchdog sized well above the longest expected sequence.
   initial begin
      repeat (90000) @(posedge clk_sys_i);
      n_errors++;
      $display("CHECK FAILED at %0t: watchdog expired", $time);
      stop_test();
   end
endmodule
`default_nettype wire
